// ---- design/lcdhi_regs.svh ----
`ifndef LCDHI_REGS_SVH
`define LCDHI_REGS_SVH

// function set instruction: opcode in bits 7..5, width bit at 4
`define LCDHI_FSET_OP 3'h1
`define LCDHI_FSET_MSB 7
`define LCDHI_FSET_LSB 5
`define LCDHI_DL_BIT 4
`define LCDHI_DL_RESET 1'h1
// serial control byte fields
`define LCDHI_CO_BIT 7
`define LCDHI_RS_BIT 6
// plain default for the serial slave address
`define LCDHI_SLAVE_ADDR 7'h3A
`define LCDHI_FIFO_WIDTH 9
`define LCDHI_FIFO_DEPTH 32
`define LCDHI_LANES_WIDE 8'hFF
`define LCDHI_LANES_NARROW 8'hF0
`define LCDHI_LANES_OFF 8'h00
`define LCDHI_NIBBLE_ZERO 4'h0
`define LCDHI_LAST_BIT 3'h7

`endif

// ---- design/lcdhi_pkg.sv ----
package lcdhi_pkg;

  typedef enum logic [5:0] {
    LCDHI_S_IDLE = 6'h01,
    LCDHI_S_RX   = 6'h02,
    LCDHI_S_ACK  = 6'h04,
    LCDHI_S_TX   = 6'h08,
    LCDHI_S_RACK = 6'h10,
    LCDHI_S_WAIT = 6'h20
  } lcdhi_ser_st_t;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    lcdhi_ser_st_t st;
    logic [2:0] bitcnt;
    logic full;
    logic [7:0] sh;
    logic addr_ph;
    logic ctl_ph;
    logic co;
    logic rs;
    logic rd;
    logic oe;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_rs;
    logic rd_adv;
  } lcdhi_ser_t;

  typedef struct packed {
    logic tg;
    logic rs;
    logic rw;
    logic [7:0] data;
  } lcdhi_link_t;

  typedef struct packed {
    logic str1;
    logic str2;
    logic rw1;
    logic rw2;
    logic rs1;
    logic rs2;
    logic tg1;
    logic tg2;
    logic tg3;
    logic dl;
    logic lo;
    logic [3:0] hi;
    logic [7:0] oe;
    logic [7:0] dout;
    logic adv;
    logic pv;
    logic [7:0] pbyte;
    logic prs;
  } lcdhi_top_t;

endpackage : lcdhi_pkg

// ---- design/lcdhi_fifo.sv ----
`timescale 1ns/1ns
module lcdhi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // refused at elaboration: the pointers wrap by plain overflow
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
    $error("lcdhi_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } lcdhi_fifo_t;

  lcdhi_fifo_t q;
  lcdhi_fifo_t d;
  logic push;
  logic load;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.ov;
  assign out_data = q.od;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    push = in_valid && in_ready;
    // output register refills as soon as it empties, so it never stalls
    load = (q.cnt != '0) && (!q.ov || out_ready);
    if (q.ov && out_ready) begin
      d.ov = 1'b0;
    end
    if (load) begin
      d.od = q.mem[q.rp];
      d.ov = 1'b1;
      d.rp = q.rp + AW'(1);
    end
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = q.wp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : lcdhi_fifo

// ---- design/lcdhi_serial.sv ----
`timescale 1ns/1ns
`include "lcdhi_regs.svh"
module lcdhi_serial #(
  parameter logic [6:0] SLAVE_ADDR = `LCDHI_SLAVE_ADDR
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_rs,
  input wire logic rx_ready,
  input wire logic [7:0] tx_status,
  input wire logic [7:0] tx_data,
  output logic rd_adv
);
  lcdhi_pkg::lcdhi_ser_t q;
  lcdhi_pkg::lcdhi_ser_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign sda_oe = q.oe;
  assign rx_valid = q.rx_valid;
  assign rx_byte = q.rx_byte;
  assign rx_rs = q.rx_rs;
  assign rd_adv = q.rd_adv;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.scl1 = scl_in;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = sda_in;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.rx_valid = 1'b0;
    d.rd_adv = 1'b0;
    scl_rise = q.scl2 && !q.scl3;
    scl_fall = !q.scl2 && q.scl3;
    // sda moving while scl stays high is a control condition
    start_c = q.scl2 && q.scl3 && q.sda3 && !q.sda2;
    stop_c = q.scl2 && q.scl3 && !q.sda3 && q.sda2;
    if (start_c) begin
      d.st = lcdhi_pkg::LCDHI_S_RX;
      d.bitcnt = '0;
      d.full = 1'b0;
      d.addr_ph = 1'b1;
      d.oe = 1'b0;
    end else if (stop_c) begin
      d.st = lcdhi_pkg::LCDHI_S_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        lcdhi_pkg::LCDHI_S_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda2};
            d.bitcnt = q.bitcnt + 3'h1;
            d.full = q.bitcnt == `LCDHI_LAST_BIT;
          end else if (scl_fall && q.full) begin
            d.st = lcdhi_pkg::LCDHI_S_ACK;
            d.oe = 1'b1;
            if (q.addr_ph) begin
              d.addr_ph = 1'b0;
              d.ctl_ph = 1'b1;
              d.rd = q.sh[0];
              if (q.sh[7:1] != SLAVE_ADDR) begin
                d.st = lcdhi_pkg::LCDHI_S_WAIT;
                d.oe = 1'b0;
              end
            end else if (q.ctl_ph) begin
              d.co = q.sh[`LCDHI_CO_BIT];
              d.rs = q.sh[`LCDHI_RS_BIT];
              d.ctl_ph = 1'b0;
            end else if (rx_ready) begin
              d.rx_valid = 1'b1;
              d.rx_byte = q.sh;
              d.rx_rs = q.rs;
              d.ctl_ph = q.co;
            end else begin
              // no room: refuse the byte with a missing acknowledge
              d.st = lcdhi_pkg::LCDHI_S_WAIT;
              d.oe = 1'b0;
            end
          end
        end
        lcdhi_pkg::LCDHI_S_ACK: begin
          if (scl_fall) begin
            d.bitcnt = '0;
            d.full = 1'b0;
            if (q.rd) begin
              d.sh = q.rs ? tx_data : tx_status;
              d.oe = q.rs ? !tx_data[7] : !tx_status[7];
              d.st = lcdhi_pkg::LCDHI_S_TX;
            end else begin
              d.oe = 1'b0;
              d.st = lcdhi_pkg::LCDHI_S_RX;
            end
          end
        end
        lcdhi_pkg::LCDHI_S_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == `LCDHI_LAST_BIT) begin
              d.oe = 1'b0;
              d.st = lcdhi_pkg::LCDHI_S_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = !q.sh[6];
              d.bitcnt = q.bitcnt + 3'h1;
            end
          end
        end
        lcdhi_pkg::LCDHI_S_RACK: begin
          if (scl_rise) begin
            if (q.sda2) begin
              d.st = lcdhi_pkg::LCDHI_S_WAIT;
            end else begin
              d.rd_adv = q.rs;
              d.st = lcdhi_pkg::LCDHI_S_ACK;
            end
          end
        end
        lcdhi_pkg::LCDHI_S_WAIT: begin
          d.oe = 1'b0;
        end
        lcdhi_pkg::LCDHI_S_IDLE: begin
          d.oe = 1'b0;
        end
        default: begin
          d.st = lcdhi_pkg::LCDHI_S_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= lcdhi_pkg::LCDHI_S_IDLE;
    end else begin
      q <= d;
    end
  end

endmodule : lcdhi_serial

// ---- design/lcdhi_top.sv ----
`timescale 1ns/1ns
`include "lcdhi_regs.svh"
module lcdhi_top #(
  parameter logic [6:0] SLAVE_ADDR = `LCDHI_SLAVE_ADDR,
  parameter int FIFO_DEPTH = `LCDHI_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_strobe,
  input wire logic register_select,
  input wire logic read_not_write,
  input wire logic [7:0] parallel_data_lines_in,
  output logic [7:0] parallel_data_lines_out,
  output logic [7:0] parallel_data_lines_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic core_busy,
  input wire logic [6:0] address_counter,
  input wire logic [7:0] read_holding_register,
  output logic read_advance,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [7:0] cmd_byte,
  output logic cmd_is_data,
  output logic interface_width_bit
);
  lcdhi_pkg::lcdhi_top_t q;
  lcdhi_pkg::lcdhi_top_t d;
  lcdhi_pkg::lcdhi_link_t lk;
  lcdhi_pkg::lcdhi_link_t lk_d;
  logic fifo_in_ready;
  logic ser_rx_valid;
  logic [7:0] ser_rx_byte;
  logic ser_rx_rs;
  logic ser_rd_adv;
  logic busy;
  logic ev;
  logic done;
  logic [7:0] word;
  logic [7:0] rd_word;

  function automatic logic lcdhi_is_fset(input logic rs, input logic [7:0] b);
    return !rs && (b[`LCDHI_FSET_MSB:`LCDHI_FSET_LSB] == `LCDHI_FSET_OP);
  endfunction : lcdhi_is_fset

  ////////////////////////////////////////////////////////////////////////////
  // strobe domain: capture on the falling edge, flag it with a toggle.
  // async clear because the strobe does not run while reset is held.
  always_comb begin
    lk_d.tg = !lk.tg;
    lk_d.rs = register_select;
    lk_d.rw = read_not_write;
    lk_d.data = parallel_data_lines_in;
  end

  always_ff @(negedge host_strobe or negedge rst_n) begin
    if (!rst_n) begin
      lk <= '0;
    end else begin
      lk <= lk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  lcdhi_serial #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_serial (
    .mclk(mclk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .rx_valid(ser_rx_valid),
    .rx_byte(ser_rx_byte),
    .rx_rs(ser_rx_rs),
    .rx_ready(fifo_in_ready && !q.pv),
    .tx_status({busy, address_counter}),
    .tx_data(read_holding_register),
    .rd_adv(ser_rd_adv)
  );

  lcdhi_fifo #(
    .WIDTH(`LCDHI_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(q.pv),
    .in_ready(fifo_in_ready),
    .in_data({q.prs, q.pbyte}),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data({cmd_is_data, cmd_byte})
  );

  assign parallel_data_lines_out = q.dout;
  assign parallel_data_lines_oe = q.oe;
  assign read_advance = q.adv;
  assign interface_width_bit = q.dl;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.str1 = host_strobe;
    d.str2 = q.str1;
    d.rw1 = read_not_write;
    d.rw2 = q.rw1;
    d.rs1 = register_select;
    d.rs2 = q.rs1;
    d.tg1 = lk.tg;
    d.tg2 = q.tg1;
    d.tg3 = q.tg2;
    d.adv = ser_rd_adv;
    // a full queue also reads as busy, which holds the host off
    busy = core_busy || !fifo_in_ready || q.pv;
    rd_word = q.rs2 ? read_holding_register : {busy, address_counter};
    ev = q.tg2 != q.tg3;
    done = 1'b0;
    word = lk.data;
    if (fifo_in_ready) begin
      d.pv = 1'b0;
    end
    if (ev) begin
      if (q.dl) begin
        done = 1'b1;
      end else if (!q.lo) begin
        d.lo = 1'b1;
        d.hi = lk.data[7:4];
      end else begin
        d.lo = 1'b0;
        done = 1'b1;
        word = {q.hi, lk.data[7:4]};
      end
      if (done && lk.rw && lk.rs) begin
        d.adv = 1'b1;
      end
      if (done && !lk.rw) begin
        d.pv = 1'b1;
        d.pbyte = word;
        d.prs = lk.rs;
        if (lcdhi_is_fset(lk.rs, word)) begin
          d.dl = word[`LCDHI_DL_BIT];
          d.lo = 1'b0;
        end
      end
    end else if (ser_rx_valid) begin
      d.pv = 1'b1;
      d.pbyte = ser_rx_byte;
      d.prs = ser_rx_rs;
      if (lcdhi_is_fset(ser_rx_rs, ser_rx_byte)) begin
        d.dl = q.dl || ser_rx_byte[`LCDHI_DL_BIT];
      end
    end
    // drive only while a read strobe is high; narrow uses upper lanes
    if (q.str2 && q.rw2) begin
      d.oe = q.dl ? `LCDHI_LANES_WIDE : `LCDHI_LANES_NARROW;
    end else begin
      d.oe = `LCDHI_LANES_OFF;
    end
    if (q.dl) begin
      d.dout = rd_word;
    end else begin
      d.dout = {q.lo ? rd_word[3:0] : rd_word[7:4], `LCDHI_NIBBLE_ZERO};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.dl <= `LCDHI_DL_RESET;
    end else begin
      q <= d;
    end
  end

endmodule : lcdhi_top

// ---- bench/lcdhi_chk_sva.sv ----
`timescale 1ns/1ns
module lcdhi_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] parallel_data_lines_out,
  input wire logic [7:0] parallel_data_lines_oe,
  input wire logic read_advance,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_is_data,
  input wire logic interface_width_bit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OE_LANES: assert property (parallel_data_lines_oe inside {8'h00, 8'hF0, 8'hFF})
    else $error("lane enable pattern illegal");
  AST_WIDE_LANES: assert property (parallel_data_lines_oe == 8'hFF |->
    interface_width_bit)
    else $error("all lanes driven in narrow mode");
  AST_NARROW_LOW: assert property (parallel_data_lines_oe == 8'hF0 |->
    !interface_width_bit && parallel_data_lines_out[3:0] == 4'h0)
    else $error("narrow read lanes wrong");
  AST_CMD_HOLD: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_byte) && $stable(cmd_is_data))
    else $error("queued byte changed before taken");
  AST_ADV_PULSE: assert property (read_advance |=> !read_advance)
    else $error("advance longer than one cycle");
  AST_ADV_AFTER: assert property (read_advance |-> parallel_data_lines_oe == 8'h00)
    else $error("advance while read data still driven");
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("serial data driven high");
  AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("serial data pulled while clock high");
  AST_SCL_HIGH_HOLD: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
    && $past(scl_in, 3) |-> $stable(sda_oe))
    else $error("serial data moved during clock high");
  AST_WIDTH_RESET: assert property ($rose(rst_n) |-> interface_width_bit)
    else $error("width bit not wide after reset");
  cover property (cmd_valid && cmd_ready);
  cover property (read_advance);
  cover property ($rose(sda_oe));
endmodule : lcdhi_chk

// ---- bench/lcdhi_host.sv ----
`timescale 1ns/1ns
module lcdhi_host (
  output logic host_strobe,
  output logic register_select,
  output logic read_not_write,
  output logic [7:0] parallel_data_lines_in,
  input wire logic [7:0] parallel_data_lines_out,
  input wire logic [7:0] parallel_data_lines_oe,
  output logic scl_in,
  output logic sda_in,
  input wire logic sda_oe
);
  logic lclk = 1'b0;
  logic drv_lo = 1'b0;
  logic narrow = 1'b0;
  logic [7:0] pins;
  logic [7:0] lastrd;
  initial begin
    host_strobe = 1'b0;
    register_select = 1'b0;
    read_not_write = 1'b0;
    parallel_data_lines_in = 8'hFF;
    scl_in = 1'b1;
    forever #15 lclk = ~lclk;
  end
  // the data line has a pull-up, so a released sda reads high; scl is driven directly
  assign sda_in = ~(sda_oe | drv_lo);
  assign pins = (parallel_data_lines_out & parallel_data_lines_oe) | ~parallel_data_lines_oe;
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask : tk
  //////////////////////////////////////////////////////////////////
  task automatic cyc(input logic rs, input logic rw, input logic [7:0] d);
    tk(1);
    register_select <= rs;
    read_not_write <= rw;
    parallel_data_lines_in <= d;
    tk(2);
    host_strobe <= 1'b1;
    tk(8);
    lastrd = pins;
    host_strobe <= 1'b0;
    tk(2);
    parallel_data_lines_in <= 8'hFF;
    tk(14);
  endtask : cyc
  task automatic pwr(input logic rs, input logic [7:0] b);
    if (narrow) begin
      cyc(rs, 1'b0, {b[7:4], 4'hF});
      cyc(rs, 1'b0, {b[3:0], 4'hF});
    end else begin
      cyc(rs, 1'b0, b);
    end
  endtask : pwr
  task automatic prd(input logic rs, output logic [7:0] v);
    cyc(rs, 1'b1, 8'hFF);
    v = lastrd;
    if (narrow) begin
      cyc(rs, 1'b1, 8'hFF);
      v = {v[7:4], lastrd[7:4]};
    end
  endtask : prd
  //////////////////////////////////////////////////////////////////
  task automatic sbit(input logic b, output logic seen);
    drv_lo <= ~b;
    tk(8);
    scl_in <= 1'b1;
    tk(4);
    seen = sda_in;
    tk(4);
    scl_in <= 1'b0;
    tk(2);
  endtask : sbit
  task automatic sbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) sbit(b[i], s);
    sbit(1'b1, s);
    ack = ~s;
  endtask : sbyte
  // master receiver: eight released bits, then ack low or nack high
  task automatic sread(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++) begin
      sbit(1'b1, s);
      v = {v[6:0], s};
    end
    sbit(nack, s);
  endtask : sread
  task automatic sstart;
    tk(8);
    drv_lo <= 1'b1;
    tk(8);
    scl_in <= 1'b0;
    tk(4);
  endtask : sstart
  task automatic sstop;
    drv_lo <= 1'b1;
    tk(8);
    scl_in <= 1'b1;
    tk(8);
    drv_lo <= 1'b0;
    tk(8);
  endtask : sstop
endmodule : lcdhi_host

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`include "lcdhi_regs.svh"
module testbench;
  logic mclk, rst_n, host_strobe, register_select, read_not_write, scl_in, sda_in, sda_out;
  logic sda_oe, core_busy, read_advance, cmd_valid, cmd_ready, cmd_is_data, interface_width_bit;
  logic [7:0] parallel_data_lines_in, parallel_data_lines_out, parallel_data_lines_oe;
  logic [7:0] read_holding_register, cmd_byte;
  logic [6:0] address_counter;
  logic [7:0] n_adv = 8'h00;
  int bad_count = 0;
  int samples_checked = 0;
  lcdhi_top #(.FIFO_DEPTH(4)) i_lcdhi_top (.mclk, .rst_n, .host_strobe, .register_select,
    .read_not_write, .parallel_data_lines_in, .parallel_data_lines_out, .parallel_data_lines_oe,
    .scl_in, .sda_in, .sda_out, .sda_oe, .core_busy, .address_counter, .read_holding_register,
    .read_advance, .cmd_valid, .cmd_ready, .cmd_byte, .cmd_is_data, .interface_width_bit);
  lcdhi_host i_lcdhi_host (.host_strobe, .register_select, .read_not_write,
    .parallel_data_lines_in, .parallel_data_lines_out, .parallel_data_lines_oe, .scl_in,
    .sda_in, .sda_oe);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (read_advance === 1'b1) n_adv <= n_adv + 8'h01;
  //////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic take(input logic [7:0] b, input logic r);
    int n;
    n = 0;
    while (cmd_valid !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (cmd_valid !== 1'b1) begin
      bad_count++;
      $display("[ERR] cmd_valid expected 1 seen %b", cmd_valid);
      results();
    end
    chk("cmd_byte", b, cmd_byte);
    chk("cmd_is_data", {7'h00, r}, {7'h00, cmd_is_data});
    cmd_ready <= 1'b1;
    @(posedge mclk);
    cmd_ready <= 1'b0;
    @(posedge mclk);
  endtask : take
  //////////////////////////////////////////////////////////////////
  task automatic t_wide;
    logic [7:0] v, a0;
    chk("width bit", 8'h01, {7'h00, interface_width_bit});
    i_lcdhi_host.pwr(1'b1, 8'hA5);
    take(8'hA5, 1'b1);
    core_busy <= 1'b1;
    a0 = n_adv;
    i_lcdhi_host.prd(1'b0, v);
    chk("status", 8'hA5, v);
    core_busy <= 1'b0;
    i_lcdhi_host.prd(1'b1, v);
    chk("read data", 8'h3C, v);
    chk("advance count", a0 + 8'h01, n_adv);
    $display("wide done");
  endtask : t_wide
  task automatic t_serial;
    logic a;
    i_lcdhi_host.sstart();
    i_lcdhi_host.sbyte({`LCDHI_SLAVE_ADDR, 1'b0}, a);
    chk("ack address", 8'h01, {7'h00, a});
    i_lcdhi_host.sbyte(8'h00, a);
    i_lcdhi_host.sbyte(8'h20, a);
    i_lcdhi_host.sbyte(8'h55, a);
    chk("ack data", 8'h01, {7'h00, a});
    i_lcdhi_host.sstop();
    take(8'h20, 1'b0);
    take(8'h55, 1'b0);
    chk("width bit", 8'h01, {7'h00, interface_width_bit});
    i_lcdhi_host.sstart();
    i_lcdhi_host.sbyte({`LCDHI_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
    chk("ack other address", 8'h00, {7'h00, a});
    i_lcdhi_host.sstop();
    $display("serial done");
  endtask : t_serial
  // control byte picks status (rs 0) or data (rs 1), then two bytes are read back
  task automatic t_sread;
    logic a;
    logic [7:0] v, a0, x;
    for (int k = 0; k < 2; k++) begin
      x = k[0] ? 8'h3C : 8'h25;
      i_lcdhi_host.sstart();
      i_lcdhi_host.sbyte({`LCDHI_SLAVE_ADDR, 1'b0}, a);
      i_lcdhi_host.sbyte({1'b0, k[0], 6'h00}, a);
      chk("ack control", 8'h01, {7'h00, a});
      i_lcdhi_host.sstop();
      a0 = n_adv;
      i_lcdhi_host.sstart();
      i_lcdhi_host.sbyte({`LCDHI_SLAVE_ADDR, 1'b1}, a);
      chk("ack read address", 8'h01, {7'h00, a});
      i_lcdhi_host.sread(1'b0, v);
      chk("serial read acked", x, v);
      i_lcdhi_host.sread(1'b1, v);
      chk("serial read last", x, v);
      chk("sda released", 8'h00, {7'h00, sda_oe});
      i_lcdhi_host.sstop();
      chk("serial advance", a0 + 8'(k), n_adv);
    end
    $display("serial read done");
  endtask : t_sread
  task automatic t_fill;
    logic [7:0] v;
    // four in the queue plus the output stage; the sixth waits as pending
    for (int i = 0; i < 6; i++) i_lcdhi_host.pwr(1'b1, 8'h10 + 8'(i));
    i_lcdhi_host.prd(1'b0, v);
    chk("busy when full", 8'h01, {7'h00, v[7]});
    for (int i = 0; i < 6; i++) take(8'h10 + 8'(i), 1'b1);
    chk("drained", 8'h00, {7'h00, cmd_valid});
    $display("fill done");
  endtask : t_fill
  task automatic t_narrow;
    logic [7:0] v;
    i_lcdhi_host.pwr(1'b0, 8'h20);
    take(8'h20, 1'b0);
    chk("width bit", 8'h00, {7'h00, interface_width_bit});
    i_lcdhi_host.narrow = 1'b1;
    i_lcdhi_host.cyc(1'b1, 1'b0, 8'hCF);
    repeat (10) @(posedge mclk);
    chk("one nibble", 8'h00, {7'h00, cmd_valid});
    i_lcdhi_host.cyc(1'b1, 1'b0, 8'h7F);
    take(8'hC7, 1'b1);
    core_busy <= 1'b1;
    i_lcdhi_host.prd(1'b0, v);
    chk("nibble status", 8'hA5, v);
    core_busy <= 1'b0;
    i_lcdhi_host.prd(1'b1, v);
    chk("nibble data", 8'h3C, v);
    $display("narrow done");
  endtask : t_narrow
  // reset in mid-run with a byte queued and narrow mode set
  task automatic t_reset;
    i_lcdhi_host.pwr(1'b1, 8'h99);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    i_lcdhi_host.narrow = 1'b0;
    repeat (3) @(posedge mclk);
    chk("width bit after reset", 8'h01, {7'h00, interface_width_bit});
    chk("queue after reset", 8'h00, {7'h00, cmd_valid});
    i_lcdhi_host.pwr(1'b1, 8'h6B);
    take(8'h6B, 1'b1);
    $display("reset done");
  endtask : t_reset
  //////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    core_busy = 1'b0;
    cmd_ready = 1'b0;
    address_counter = 7'h25;
    read_holding_register = 8'h3C;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_wide();
    t_serial();
    t_sread();
    t_fill();
    t_narrow();
    t_reset();
    results();
  end
endmodule : testbench
bind lcdhi_top lcdhi_chk i_lcdhi_chk (.mclk, .rst_n, .scl_in, .sda_out, .sda_oe,
  .parallel_data_lines_out, .parallel_data_lines_oe, .read_advance, .cmd_valid, .cmd_ready,
  .cmd_byte, .cmd_is_data, .interface_width_bit);
